/* File: bench/reg_space_model.sv */
// register space model answering the mapper's access requests
`default_nettype none
module reg_space_model (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_n_i,
   // access port
   input wire fb_types_pkg::reg_req_t req_i,
   input wire logic slow_i,
   output logic ack_o,
   output logic err_o,
   output logic [15:0] rdata_o,
   output int wr_cnt_o
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================
   // storage, two bytes a register
   localparam logic [15:0] BAD_ADDR = 16'h0040;
   logic [15:0] mem [256];
   logic [1:0] wait_r;
   initial for (int i = 0; i < 256; i++) mem[i] = {8'hc3, i[7:0]};
   // off-ack data inverted so a stale sample never matches
   assign rdata_o = ack_o ? mem[req_i.addr[7:0]] : ~mem[req_i.addr[7:0]];
   assign err_o = ack_o && (req_i.addr == BAD_ADDR);
   // ==========================================
   // answer after zero or two idle cycles
   always @(posedge clk_i) begin
      if (!rst_n_i) begin
         ack_o <= 1'b0;
         wait_r <= 2'h0;
         wr_cnt_o <= 0;
      end else if (ack_o) begin
         ack_o <= 1'b0;
         wait_r <= 2'h0;
         if (req_i.we && !err_o) begin
            mem[req_i.addr[7:0]] <= req_i.wdata;
            wr_cnt_o <= wr_cnt_o + 1;
         end
      end else if (req_i.req) begin
         if (wait_r == (slow_i ? 2'h2 : 2'h0)) ack_o <= 1'b1;
         else wait_r <= wait_r + 2'h1;
      end
   end
endmodule : reg_space_model
`default_nettype wire

/* File: bench/tb_top.sv */
// self-checking bench for the fieldbus process image mapper
`default_nettype none
`include "fb_image_params.svh"
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk;
   logic rst_n;
   logic [127:0] out_img;
   fb_types_pkg::instr_hdr_t hdr;
   fb_types_pkg::scale_stat_t sstat;
   fb_types_pkg::int_vals_t ival;
   fb_types_pkg::flt_vals_t fval;
   fb_types_pkg::reg_req_t req;
   logic fmode;
   logic ack;
   logic rerr;
   logic slow;
   logic [15:0] rdata;
   logic sreq;
   logic sdone;
   logic sfail;
   logic prst;
   logic [7:0] scode;
   logic [7:0] serrc;
   logic [639:0] img;
   int wr_cnt;
   int err_total;
   int checks_done;
   int prst_seen;

   fieldbus_image_mapper dut (.REF_CLK_I(clk), .RESET_N_I(rst_n), .OUT_IMAGE_I(out_img),
      .INSTR_HDR_I(hdr), .SCALE_STAT_I(sstat), .INT_VALS_I(ival), .FLT_VALS_I(fval),
      .FLOAT_MODE_I(fmode), .REG_REQ_O(req), .REG_ACK_I(ack), .REG_ERR_I(rerr),
      .REG_RDATA_I(rdata), .SCALE_REQ_O(sreq), .SCALE_CODE_O(scode), .SCALE_DONE_I(sdone),
      .SCALE_FAIL_I(sfail), .SCALE_ERRC_I(serrc), .PRST_CLR_O(prst), .IN_IMAGE_O(img));
   reg_space_model model (.clk_i(clk), .rst_n_i(rst_n), .req_i(req), .slow_i(slow),
      .ack_o(ack), .err_o(rerr), .rdata_o(rdata), .wr_cnt_o(wr_cnt));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ==========================================
   // helpers
   function automatic logic [7:0] ib(int n);
      return img[639-8*n -: 8];
   endfunction : ib
   task automatic chk(string what, logic [191:0] exp, logic [191:0] got);
      checks_done++;
      if (exp !== got) begin
         err_total++;
         $display("wrong value %s expected %0h seen %0h", what, exp, got);
      end
   endtask : chk
   task automatic close_out();
      $display("mismatches %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : close_out
   task automatic send(logic [7:0] c, logic [7:0] n, logic [15:0] a, logic [31:0] d);
      @(posedge clk);
      out_img <= {c, n, a, d, ~d, d};
   endtask : send
   // ack byte must move to the expected code; a lapsed bound ends the run
   task automatic wait_ack(logic [7:0] a, logic [7:0] e);
      int k;
      prst_seen = 0;
      for (k = 0; k < 200 && ib(4) !== a; k++) begin
         @(posedge clk);
         #1;
         if (prst === 1'b1) prst_seen++;
      end
      chk("ack", a, ib(4));
      if (k == 200) close_out();
      chk("cmd error", e, ib(5));
   endtask : wait_ack
   // ==========================================
   // scenarios
   task automatic layout_check();
      @(posedge clk) hdr <= 24'h0c0d0e;
      repeat (3) @(posedge clk);
      #1;
      chk("header", {hdr, 8'h00}, img[639:608]);
      chk("scale status", sstat, img[383:320]);
      chk("integer values", ival, img[319:128]);
      chk("reserved", 128'h0, img[127:0]);
      @(posedge clk) fmode <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      chk("float values", {fval, 32'h0}, img[319:128]);
      chk("reserved float", 128'h0, img[127:0]);
      @(posedge clk) fmode <= 1'b0;
   endtask : layout_check
   task automatic write_cases();
      send(8'hfb, 8'h02, 16'h0020, 32'h12345678);
      wait_ack(8'hfb, 8'h00);
      chk("writes", 2, wr_cnt);
      send(8'hfb, 8'h02, 16'h0020, 32'h9abcdef0);
      repeat (30) @(posedge clk);
      #1;
      chk("same command ignored", 2, wr_cnt);
      send(8'h00, 8'h02, 16'h0020, 32'h9abcdef0);
      repeat (30) @(posedge clk);
      #1;
      chk("no action ack", 8'hfb, ib(4));
      send(8'hfb, 8'h02, 16'h0020, 32'h9abcdef0);
      repeat (30) @(posedge clk);
      #1;
      chk("repeat after change", 4, wr_cnt);
      send(8'h00, 8'h07, 16'h0020, 32'h0);
      send(8'hfb, 8'h07, 16'h0020, 32'h0);
      wait_ack(`ACK_FAIL, `ERR_COUNT);
      chk("bad count writes", 4, wr_cnt);
      send(8'hfc, 8'h00, 16'h0000, 32'h0);
      wait_ack(8'hfc, 8'h00);
      chk("prst pulses", 1, prst_seen);
      send(8'hfb, 8'h02, 16'h003f, 32'h11112222);
      wait_ack(`ACK_FAIL, `ERR_BUS);
      chk("aborted writes", 5, wr_cnt);
      send(8'h00, 8'h00, 16'h0000, 32'h0);
      send(8'hfb, 8'h06, 16'h0022, 32'h13579bdf);
      wait_ack(8'hfb, 8'h00);
      chk("six writes", 11, wr_cnt);
      send(8'h00, 8'h02, 16'hffff, 32'h0);
      send(8'hfb, 8'h02, 16'hffff, 32'h0);
      wait_ack(`ACK_FAIL, `ERR_ADDR);
      chk("bad address writes", 11, wr_cnt);
   endtask : write_cases
   task automatic window_case();
      logic [191:0] w;
      // model fill pattern plus the two earlier writes into the window
      w = {16'hc31e, 16'hc31f, 16'h9abc, 16'hdef0, 32'h13579bdf, 32'heca86420, 32'h13579bdf,
         16'hc328, 16'hc329};
      @(posedge clk) slow <= 1'b1;
      send(8'hfa, 8'h00, 16'h001e, 32'h0);
      wait_ack(8'hfa, 8'h00);
      repeat (200) @(posedge clk);
      #1;
      chk("window address", 16'h001e, {ib(6), ib(7)});
      for (int k = 0; k < 12; k++) begin
         chk("window reg", w[191-16*k -: 16], {ib(8 + 2 * k), ib(9 + 2 * k)});
      end
      send(8'h00, 8'h00, 16'h0000, 32'h0);
      send(8'hfa, 8'h00, 16'hfff8, 32'h0);
      wait_ack(`ACK_FAIL, `ERR_ADDR);
      chk("window kept", 16'h001e, {ib(6), ib(7)});
   endtask : window_case
   task automatic scale_cmd(logic [7:0] c, logic f, logic [7:0] ec, logic [7:0] ea);
      int k;
      send(c, 8'h00, 16'h0000, 32'h0);
      for (k = 0; k < 50 && sreq !== 1'b1; k++) begin
         @(posedge clk);
         #1;
      end
      chk("scale request", 1'b1, sreq);
      if (k == 50) close_out();
      chk("scale code", c, scode);
      @(posedge clk);
      sdone <= 1'b1;
      sfail <= f;
      serrc <= ec;
      @(posedge clk) sdone <= 1'b0;
      wait_ack(ea, f ? ec : 8'h00);
   endtask : scale_cmd
   // ==========================================
   // main sequence
   initial begin
      err_total = 0;
      checks_done = 0;
      prst_seen = 0;
      rst_n = 1'b0;
      out_img = 128'h0;
      hdr = 24'ha1b2c3;
      sstat = 64'h1122334455667788;
      ival = 192'h11112222333344445555666677778888999aaaabbbbcccc;
      fval = 160'hf1f2f3f4e1e2e3e4d1d2d3d4c1c2c3c4b1b2b3b4;
      fmode = 1'b0;
      slow = 1'b0;
      sdone = 1'b0;
      sfail = 1'b0;
      serrc = 8'h00;
      repeat (4) @(posedge clk);
      #1;
      chk("image in reset", 1'b0, |img);
      @(posedge clk) rst_n <= 1'b1;
      layout_check();
      write_cases();
      window_case();
      scale_cmd(8'h05, 1'b0, 8'h00, 8'h05);
      scale_cmd(8'h06, 1'b1, 8'h21, `ACK_FAIL);
      close_out();
   end
endmodule : tb_top
`default_nettype wire

/* File: rtl/cmd_change_det.sv */
// command byte change detector with pending latch
`default_nettype none
`include "fb_image_params.svh"
module cmd_change_det #(
   parameter int OUT_W = 8 * `OUT_IMG_BYTES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [OUT_W-1:0] img_i,
   input wire logic take_i,
   output logic pend_o,
   output logic [OUT_W-1:0] cap_o
);
   typedef struct packed {
      logic [7:0] prev;
      logic pend;
      logic [OUT_W-1:0] cap;
   } det_t;
   det_t r;
   det_t n;
   always_comb begin
      n = r;
      if (take_i) begin
         n.pend = 1'b0;
      end
      // a change in the take cycle still counts: set wins
      if (img_i[OUT_W-1 -: 8] != r.prev) begin
         n.pend = 1'b1;
         n.cap = img_i;
      end
      n.prev = img_i[OUT_W-1 -: 8];
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end
   assign pend_o = r.pend;
   assign cap_o = r.cap;
endmodule : cmd_change_det
`default_nettype wire

/* File: rtl/fb_image_params.svh */
// constants for the fieldbus process image mapper
`ifndef FB_IMAGE_PARAMS_SVH
`define FB_IMAGE_PARAMS_SVH
// ==========================================
// image sizes
`define OUT_IMG_BYTES 16
`define IN_IMG_BYTES 80
`define WIN_REGS 12
`define WR_REGS_MAX 6
// ==========================================
// command codes and answers
`define CMD_NONE 8'h00
`define CMD_WINDOW 8'hfa
`define CMD_WRITE 8'hfb
`define CMD_CLR_PRST 8'hfc
`define ACK_FAIL 8'hf0
`define ERR_OK 8'h00
`define ERR_COUNT 8'h01
`define ERR_ADDR 8'h02
`define ERR_BUS 8'h03
`define ERR_SCALE 8'h04
// ==========================================
// input image byte offsets
`define IB_ACK 4
`define IB_CERR 5
`define IB_WADDR 6
`define IB_WIN 8
`define IB_SETP 32
`define IB_SERR 36
`define IB_SSTAT 38
`define IB_GROSS 40
`define IB_NET 44
`define IB_WDEC 48
`define IB_FLOW 50
`define IB_FDEC 54
`define IB_SIG 56
`define IB_AOUT 60
`define IF_FLOW 48
`define IF_SIG 52
`define IF_AOUT 56
`endif

/* File: rtl/fb_types_pkg.sv */
// types shared by the process image mapper
`default_nettype none
package fb_types_pkg;
   // ==========================================
   // states of the command sequencer
   typedef enum logic [1:0] {
      S_IDLE = 2'b00,
      S_READ = 2'b01,
      S_WRITE = 2'b10,
      S_SCALE = 2'b11
   } seq_state_t;
   // ==========================================
   // header, status and value bytes from the instrument
   typedef struct packed {
      logic [7:0] state;
      logic [7:0] error;
      logic [7:0] status;
   } instr_hdr_t;
   typedef struct packed {
      logic [7:0] setpoint;
      logic [7:0] level;
      logic [7:0] din;
      logic [7:0] dout;
      logic [15:0] scale_err;
      logic [15:0] scale_stat;
   } scale_stat_t;
   typedef struct packed {
      logic [31:0] gross;
      logic [31:0] net;
      logic [15:0] wdec;
      logic [31:0] flow;
      logic [15:0] fdec;
      logic [31:0] signal;
      logic [31:0] aout;
   } int_vals_t;
   typedef struct packed {
      logic [31:0] gross;
      logic [31:0] net;
      logic [31:0] flow;
      logic [31:0] signal;
      logic [31:0] aout;
   } flt_vals_t;
   // register space access
   typedef struct packed {
      logic req;
      logic we;
      logic [15:0] addr;
      logic [15:0] wdata;
   } reg_req_t;
endpackage : fb_types_pkg
`default_nettype wire

/* File: rtl/fieldbus_image_mapper.sv */
// command mailbox and process image mapper between fieldbus master and register space
`default_nettype none
`include "fb_image_params.svh"
// Contract
// R1 - take 16 byte output image from master
// R2 - multi byte values most significant first
// R3 - out bytes: command, count, address, six registers
// R4 - every register is two bytes wide
// R5 - command byte drives window, writes, scale actions
// R6 - 0 nothing, 250 window, 251 write
// R7 - 252 clears program reset flag
// R8 - act only when command byte changes
// R9 - count, address, data from fixed bytes
// R10 - outcome in bytes 4 and 5
// R11 - ack is command or 240 on failure
// R12 - error byte zero on success, else code
// R13 - produce 80 byte input image
// R14 - header: state, error, status, unused
// R15 - bytes 6-7 echo window start address
// R16 - bytes 8-31 hold twelve window registers
// R17 - status, scale error, scale status bytes
// R18 - integer value layout from byte 40
// R19 - float layout, bytes 60-63 zero
// R20 - setup selects integer or float layout
// R21 - bytes 64-79 reserved, carry zero
// R22 - master mapping matches device mapping
// R23 - bad count or address writes nothing
module fieldbus_image_mapper #(
   parameter logic [15:0] ADDR_LO = 16'h0000,
   parameter logic [15:0] ADDR_HI = 16'hffff,
   parameter logic [15:0] WIN_ADDR_RST = 16'h0000
) (
   // clock and reset
   input wire logic REF_CLK_I,
   input wire logic RESET_N_I,
   // output image from the master
   input wire logic [8*`OUT_IMG_BYTES-1:0] OUT_IMAGE_I,
   // instrument data for the input image
   input wire fb_types_pkg::instr_hdr_t INSTR_HDR_I,
   input wire fb_types_pkg::scale_stat_t SCALE_STAT_I,
   input wire fb_types_pkg::int_vals_t INT_VALS_I,
   input wire fb_types_pkg::flt_vals_t FLT_VALS_I,
   input wire logic FLOAT_MODE_I,
   // register space access
   output fb_types_pkg::reg_req_t REG_REQ_O,
   input wire logic REG_ACK_I,
   input wire logic REG_ERR_I,
   input wire logic [15:0] REG_RDATA_I,
   // scale command port
   output logic SCALE_REQ_O,
   output logic [7:0] SCALE_CODE_O,
   input wire logic SCALE_DONE_I,
   input wire logic SCALE_FAIL_I,
   input wire logic [7:0] SCALE_ERRC_I,
   // program reset flag clear and input image
   output logic PRST_CLR_O,
   output logic [8*`IN_IMG_BYTES-1:0] IN_IMAGE_O
);
   localparam int OUT_W = 8 * `OUT_IMG_BYTES;
   localparam int IN_W = 8 * `IN_IMG_BYTES;

   // ==========================================
   // state
   typedef struct packed {
      fb_types_pkg::seq_state_t st;
      logic [7:0] ack;
      logic [7:0] cerr;
      logic [15:0] win_addr;
      logic [`WIN_REGS-1:0][15:0] win;
      logic [3:0] rd_idx;
      logic [2:0] wr_idx;
      logic [2:0] wr_cnt;
      logic [`WR_REGS_MAX-1:0][15:0] wr_data;
      fb_types_pkg::reg_req_t rq;
      logic scale_req;
      logic [7:0] scale_code;
      logic prst_clr;
   } map_t;
   map_t r;
   map_t n;

   logic pend;
   logic take;
   logic [OUT_W-1:0] cap;
   logic [7:0] cap_cmd;
   logic [7:0] cap_cnt;
   logic [15:0] cap_addr;

   // ==========================================
   // command capture
   cmd_change_det #(
      .OUT_W(OUT_W)
   ) u_det (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESET_N_I),
      .img_i(OUT_IMAGE_I), // R1
      .take_i(take),
      .pend_o(pend), // R8
      .cap_o(cap)
   );

   assign cap_cmd = cap[OUT_W-1 -: 8]; // R3
   assign cap_cnt = cap[OUT_W-9 -: 8]; // R9
   assign cap_addr = cap[OUT_W-17 -: 16]; // R2 R9

   // range check of a run of registers; no wrap past the top
   function automatic logic addr_ok(input logic [15:0] a, input logic [4:0] cnt);
      logic [16:0] last;
      last = {1'b0, a} + {12'h000, cnt} - 17'h00001;
      return (a >= ADDR_LO) && (last <= {1'b0, ADDR_HI});
   endfunction : addr_ok

   // ==========================================
   // sequencer
   always_comb begin
      n = r;
      take = 1'b0;
      n.prst_clr = 1'b0;
      case (r.st)
         fb_types_pkg::S_IDLE: begin
            if (pend) begin
               take = 1'b1;
               case (cap_cmd) // R5 R6
                  `CMD_NONE: begin
                     n.st = fb_types_pkg::S_IDLE;
                  end
                  `CMD_WINDOW: begin
                     if (addr_ok(cap_addr, 5'd12)) begin
                        n.win_addr = cap_addr; // R15
                        n.rd_idx = 4'h0;
                        n.ack = `CMD_WINDOW; // R11
                        n.cerr = `ERR_OK; // R12
                     end else begin
                        n.ack = `ACK_FAIL; // R11
                        n.cerr = `ERR_ADDR; // R12
                     end
                  end
                  `CMD_WRITE: begin
                     // checks up front so a bad request never touches a register
                     if (cap_cnt == 8'h00 || cap_cnt > 8'h06) begin
                        n.ack = `ACK_FAIL; // R23
                        n.cerr = `ERR_COUNT; // R23
                     end else if (!addr_ok(cap_addr, cap_cnt[4:0])) begin
                        n.ack = `ACK_FAIL; // R23
                        n.cerr = `ERR_ADDR; // R23
                     end else begin
                        for (int k = 0; k < `WR_REGS_MAX; k++) begin
                           n.wr_data[k] = cap[OUT_W-33-16*k -: 16]; // R4 R9
                        end
                        n.wr_cnt = cap_cnt[2:0];
                        n.wr_idx = 3'h0;
                        n.rq.req = 1'b1;
                        n.rq.we = 1'b1;
                        n.rq.addr = cap_addr;
                        n.rq.wdata = cap[OUT_W-33 -: 16];
                        n.st = fb_types_pkg::S_WRITE;
                     end
                  end
                  `CMD_CLR_PRST: begin
                     n.prst_clr = 1'b1; // R7
                     n.ack = `CMD_CLR_PRST;
                     n.cerr = `ERR_OK;
                  end
                  default: begin
                     // tare, zero and the rest go to the scale logic
                     n.scale_req = 1'b1; // R5
                     n.scale_code = cap_cmd;
                     n.st = fb_types_pkg::S_SCALE;
                  end
               endcase
            end else begin
               // background refresh of the window, one register per access
               n.rq.req = 1'b1; // R16
               n.rq.we = 1'b0;
               n.rq.addr = r.win_addr + {12'h000, r.rd_idx};
               n.rq.wdata = 16'h0000;
               n.st = fb_types_pkg::S_READ;
            end
         end
         fb_types_pkg::S_READ: begin
            if (REG_ACK_I) begin
               n.rq.req = 1'b0;
               n.win[r.rd_idx] = REG_ERR_I ? 16'h0000 : REG_RDATA_I; // R16
               n.rd_idx = (r.rd_idx == 4'd11) ? 4'h0 : r.rd_idx + 4'h1;
               n.st = fb_types_pkg::S_IDLE;
            end
         end
         fb_types_pkg::S_WRITE: begin
            if (REG_ACK_I) begin
               if (REG_ERR_I) begin
                  n.rq.req = 1'b0;
                  n.ack = `ACK_FAIL; // R11
                  n.cerr = `ERR_BUS; // R12
                  n.st = fb_types_pkg::S_IDLE;
               end else if (r.wr_idx == r.wr_cnt - 3'h1) begin
                  n.rq.req = 1'b0;
                  n.ack = `CMD_WRITE; // R11
                  n.cerr = `ERR_OK; // R12
                  n.st = fb_types_pkg::S_IDLE;
               end else begin
                  // next register follows back to back
                  n.wr_idx = r.wr_idx + 3'h1;
                  n.rq.addr = r.rq.addr + 16'h0001; // R6
                  n.rq.wdata = r.wr_data[r.wr_idx + 3'h1];
               end
            end
         end
         fb_types_pkg::S_SCALE: begin
            if (SCALE_DONE_I) begin
               n.scale_req = 1'b0;
               n.st = fb_types_pkg::S_IDLE;
               if (SCALE_FAIL_I) begin
                  n.ack = `ACK_FAIL; // R11
                  // a failure must never report code zero
                  n.cerr = (SCALE_ERRC_I == 8'h00) ? `ERR_SCALE : SCALE_ERRC_I; // R12
               end else begin
                  n.ack = r.scale_code; // R11
                  n.cerr = `ERR_OK;
               end
            end
         end
         default: begin
            n.st = fb_types_pkg::S_IDLE;
         end
      endcase
   end

   always_ff @(posedge REF_CLK_I) begin
      if (!RESET_N_I) begin
         r <= '0;
         r.win_addr <= WIN_ADDR_RST;
      end else begin
         r <= n;
      end
   end

   // ==========================================
   // input image
   in_image_packer #(
      .IN_W(IN_W)
   ) u_pack (
      .clk_i(REF_CLK_I),
      .rst_n_i(RESET_N_I),
      .hdr_i(INSTR_HDR_I),
      .ack_i(r.ack),
      .cerr_i(r.cerr),
      .waddr_i(r.win_addr),
      .win_i(r.win),
      .stat_i(SCALE_STAT_I),
      .ival_i(INT_VALS_I),
      .fval_i(FLT_VALS_I),
      .float_mode_i(FLOAT_MODE_I), // R20
      .img_o(IN_IMAGE_O) // R13
   );

   assign REG_REQ_O = r.rq;
   assign SCALE_REQ_O = r.scale_req;
   assign SCALE_CODE_O = r.scale_code;
   assign PRST_CLR_O = r.prst_clr;

   // ==========================================
   // checks
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!RESET_N_I);

   logic idle_take;
   assign idle_take = (r.st == fb_types_pkg::S_IDLE) && pend;

   AST_WIN_ECHO: assert property ( // R15
      ##1 IN_IMAGE_O[IN_W-1-8*`IB_WADDR -: 16] == $past(r.win_addr))
      else $error("window address echo wrong");

   AST_NO_REPEAT: assert property ( // R8
      !pend && $stable(OUT_IMAGE_I[OUT_W-1 -: 8]) |=> !pend)
      else $error("command taken without a change");

   AST_SCALE_OK: assert property ( // R11
      r.st == fb_types_pkg::S_SCALE && SCALE_DONE_I && !SCALE_FAIL_I
      |=> r.ack == $past(r.scale_code) && r.cerr == 8'h00 && !SCALE_REQ_O)
      else $error("scale command ack wrong");

   AST_SCALE_FAIL: assert property ( // R12
      r.st == fb_types_pkg::S_SCALE && SCALE_DONE_I && SCALE_FAIL_I
      |=> r.ack == 8'hf0 && r.cerr != 8'h00)
      else $error("scale failure not reported");

   AST_COUNT_REJ: assert property ( // R23
      idle_take && cap_cmd == 8'hfb && cap_cnt > 8'h06
      |=> r.ack == 8'hf0 && r.cerr == 8'h01 ##1 !(REG_REQ_O.req && REG_REQ_O.we) [*3])
      else $error("oversize write not refused");

   AST_WR_STEP: assert property ( // R6
      r.st == fb_types_pkg::S_WRITE && REG_ACK_I && !REG_ERR_I && r.wr_idx != r.wr_cnt - 3'h1
      |=> REG_REQ_O.req && REG_REQ_O.we && REG_REQ_O.addr == $past(REG_REQ_O.addr) + 16'h0001)
      else $error("write address did not step");

   AST_WR_DONE: assert property ( // R11
      r.st == fb_types_pkg::S_WRITE && REG_ACK_I && !REG_ERR_I && r.wr_idx == r.wr_cnt - 3'h1
      |=> r.ack == 8'hfb && r.cerr == 8'h00 && !REG_REQ_O.req ##1 IN_IMAGE_O[IN_W-33 -: 8] == 8'hfb)
      else $error("write completion not acknowledged");

   AST_PRST: assert property ( // R7
      idle_take && cap_cmd == 8'hfc |=> PRST_CLR_O && r.ack == 8'hfc ##1 !PRST_CLR_O)
      else $error("program reset clear pulse wrong");

   AST_FLT_ZERO: assert property ( // R19
      FLOAT_MODE_I |=> IN_IMAGE_O[IN_W-1-8*`IB_AOUT -: 32] == 32'h00000000)
      else $error("float layout bytes 60 to 63 not zero");

   AST_RSV_ZERO: assert property ( // R21
      IN_IMAGE_O[IN_W-8*64-1:0] == '0)
      else $error("reserved input bytes not zero");

   AST_WIN_TAKE: assert property ( // R6
      idle_take && cap_cmd == 8'hfa
      |=> (r.ack == 8'hfa && r.cerr == 8'h00 && r.win_addr == $past(cap_addr))
         || (r.ack == 8'hf0 && r.cerr == 8'h02 && $stable(r.win_addr)))
      else $error("window command not handled");

   AST_WR_REFUSE: assert property ( // R23
      idle_take && cap_cmd == 8'hfb
      |=> r.st == fb_types_pkg::S_WRITE
         || (r.ack == 8'hf0 && r.cerr != 8'h00 && !REG_REQ_O.req))
      else $error("refused write not reported");

   AST_NONE_KEEPS: assert property ( // R6
      idle_take && cap_cmd == 8'h00
      |=> $stable(r.ack) && $stable(r.cerr) && !PRST_CLR_O && !SCALE_REQ_O)
      else $error("command zero changed the answer");

   AST_REQ_STANDS: assert property ( // R16
      REG_REQ_O.req && !REG_ACK_I
      |=> REG_REQ_O.req && $stable(REG_REQ_O.addr) && $stable(REG_REQ_O.we)
         && $stable(REG_REQ_O.wdata))
      else $error("register request dropped before its answer");

   AST_SCALE_STANDS: assert property ( // R5
      SCALE_REQ_O && !SCALE_DONE_I |=> SCALE_REQ_O && $stable(SCALE_CODE_O))
      else $error("scale request dropped before done");

   COV_WINDOW: cover property (idle_take && cap_cmd == 8'hfa ##1 r.ack == 8'hfa);
   COV_WRITE6: cover property (r.st == fb_types_pkg::S_WRITE && r.wr_cnt == 3'h6 && r.wr_idx == 3'h5);
   COV_SCALE: cover property (r.st == fb_types_pkg::S_SCALE && SCALE_DONE_I);
   COV_FAIL: cover property (r.ack == 8'hf0);
endmodule : fieldbus_image_mapper
`default_nettype wire

/* File: rtl/in_image_packer.sv */
// builds the 80 byte input image, one clock behind its inputs
`default_nettype none
`include "fb_image_params.svh"
module in_image_packer #(
   parameter int IN_W = 8 * `IN_IMG_BYTES
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire fb_types_pkg::instr_hdr_t hdr_i,
   input wire logic [7:0] ack_i,
   input wire logic [7:0] cerr_i,
   input wire logic [15:0] waddr_i,
   input wire logic [`WIN_REGS-1:0][15:0] win_i,
   input wire fb_types_pkg::scale_stat_t stat_i,
   input wire fb_types_pkg::int_vals_t ival_i,
   input wire fb_types_pkg::flt_vals_t fval_i,
   input wire logic float_mode_i,
   output logic [IN_W-1:0] img_o
);
   typedef struct packed {
      logic [IN_W-1:0] img;
   } pk_t;
   pk_t r;
   pk_t n;
   // most significant byte first in every field
   function automatic logic [IN_W-1:0] put(input logic [IN_W-1:0] v, input int off,
                                           input int nb, input logic [31:0] d);
      logic [IN_W-1:0] o;
      o = v;
      for (int i = 0; i < nb; i++) begin
         o[IN_W-1-8*(off+i) -: 8] = d[8*(nb-1-i) +: 8]; // R2
      end
      return o;
   endfunction : put
   always_comb begin
      n.img = '0; // R21
      n.img[IN_W-1 -: 24] = hdr_i; // R14
      n.img = put(n.img, `IB_ACK, 1, {24'h000000, ack_i}); // R10
      n.img = put(n.img, `IB_CERR, 1, {24'h000000, cerr_i}); // R10
      n.img = put(n.img, `IB_WADDR, 2, {16'h0000, waddr_i}); // R15
      for (int k = 0; k < `WIN_REGS; k++) begin
         n.img = put(n.img, `IB_WIN + 2 * k, 2, {16'h0000, win_i[k]}); // R4 R16
      end
      n.img = put(n.img, `IB_SETP, 4, stat_i[63:32]); // R17
      n.img = put(n.img, `IB_SERR, 2, {16'h0000, stat_i.scale_err}); // R17
      n.img = put(n.img, `IB_SSTAT, 2, {16'h0000, stat_i.scale_stat}); // R17
      n.img = put(n.img, `IB_GROSS, 4, float_mode_i ? fval_i.gross : ival_i.gross); // R20
      n.img = put(n.img, `IB_NET, 4, float_mode_i ? fval_i.net : ival_i.net);
      if (float_mode_i) begin
         // bytes 60..63 left at zero
         n.img = put(n.img, `IF_FLOW, 4, fval_i.flow); // R19
         n.img = put(n.img, `IF_SIG, 4, fval_i.signal); // R19
         n.img = put(n.img, `IF_AOUT, 4, fval_i.aout); // R19
      end else begin
         n.img = put(n.img, `IB_WDEC, 2, {16'h0000, ival_i.wdec}); // R18
         n.img = put(n.img, `IB_FLOW, 4, ival_i.flow); // R18
         n.img = put(n.img, `IB_FDEC, 2, {16'h0000, ival_i.fdec}); // R18
         n.img = put(n.img, `IB_SIG, 4, ival_i.signal); // R18
         n.img = put(n.img, `IB_AOUT, 4, ival_i.aout); // R18
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         r <= '0;
      end else begin
         r <= n; // R13
      end
   end
   assign img_o = r.img;
endmodule : in_image_packer
`default_nettype wire
